// ===== pcpe_defines.vh
// constants for the port crossbar peripheral routing registers
// assumes inclusion by bare name from the design files
`ifndef PCPE_DEFINES_VH
`define PCPE_DEFINES_VH

// register page and addresses on the special-function bus
`define PCPE_SFR_PAGE       8'h0f
`define PCPE_ADDR_SELECT_A  8'he1
`define PCPE_ADDR_SELECT_B  8'he2

// reset values
`define PCPE_RESET_A        8'h00
`define PCPE_RESET_B        8'h00

// writable bits, reserved bits read zero
`define PCPE_WMASK_A        8'hfd
`define PCPE_WMASK_B        8'hfe

// fields of route select a
`define PCPE_A_CMP1_ASYNC   7
`define PCPE_A_CMP1_SYNC    6
`define PCPE_A_CMP0_ASYNC   5
`define PCPE_A_CMP0_SYNC    4
`define PCPE_A_TWOWIRE      3
`define PCPE_A_SPI          2
`define PCPE_A_UART         0

// fields of route select b
`define PCPE_B_TIMER1       7
`define PCPE_B_TIMER0       6
`define PCPE_B_ECI          5
`define PCPE_B_CEX_HI       4
`define PCPE_B_CEX_LO       2
`define PCPE_B_SYSTEM_CLOCK_OUT       1

// count code that software must not write
`define PCPE_CEX_RESERVED   3'h7

// request slots, lowest index is highest crossbar priority
`define PCPE_SLOTS          20
`define PCPE_SL_SCK         0
`define PCPE_SL_MISO        1
`define PCPE_SL_MOSI        2
`define PCPE_SL_NSS         3
`define PCPE_SL_SDA         4
`define PCPE_SL_SCL         5
`define PCPE_SL_CP0         6
`define PCPE_SL_CP0A        7
`define PCPE_SL_CP1         8
`define PCPE_SL_CP1A        9
`define PCPE_SL_SYSTEM_CLOCK_OUT      10
`define PCPE_SL_CAPTURE_MODULE_IO_0        11
`define PCPE_SL_ECI         17
`define PCPE_SL_T0          18
`define PCPE_SL_T1          19

`endif

// ===== pcpe_route_regs.v
// two routing registers on the special-function bus with registered read data
// assumes single-cycle read and write strobes synchronous to CLK_SYS
`timescale 1ns/1ps
`include "pcpe_defines.vh"

module pcpe_route_regs (
  // clock and reset
  input  wire       clk,
  input  wire       nrst,
  // special-function bus
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_page,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  output reg        sfr_rd_hit,
  // register contents
  output reg  [7:0] select_a,
  output reg  [7:0] select_b
);

  wire on_page;
  wire hit_a;
  wire hit_b;

  assign on_page = (sfr_page == `PCPE_SFR_PAGE);
  assign hit_a   = on_page && (sfr_addr == `PCPE_ADDR_SELECT_A);
  assign hit_b   = on_page && (sfr_addr == `PCPE_ADDR_SELECT_B);

  // writes, reserved bits held at zero
  always @(posedge clk) begin
    if (!nrst) begin
      select_a <= `PCPE_RESET_A;
      select_b <= `PCPE_RESET_B;
    end else if (sfr_wr) begin
      if (hit_a) begin
        select_a <= sfr_wdata & `PCPE_WMASK_A;
      end else if (hit_b) begin
        select_b <= sfr_wdata & `PCPE_WMASK_B;
      end
    end
  end

  // read data, other addresses answer zero with no hit
  always @(posedge clk) begin
    if (!nrst) begin
      sfr_rdata  <= 8'h00;
      sfr_rd_hit <= 1'b0;
    end else if (sfr_rd) begin
      if (hit_a) begin
        sfr_rdata  <= select_a;
        sfr_rd_hit <= 1'b1;
      end else if (hit_b) begin
        sfr_rdata  <= select_b;
        sfr_rd_hit <= 1'b1;
      end else begin
        sfr_rdata  <= 8'h00;
        sfr_rd_hit <= 1'b0;
      end
    end else begin
      sfr_rd_hit <= 1'b0;
    end
  end

endmodule

// ===== pcpe_crossbar_enables.v
// peripheral routing enables of the port crossbar: registers, request vector,
// per-slot drive values and gated pin returns toward the peripherals
// assumes the priority decoder outside places requested slots on free pins
// and returns each slot's pin level on SLOT_PIN_IN
`timescale 1ns/1ps
`include "pcpe_defines.vh"

module pcpe_crossbar_enables #(
  parameter CEX_COUNT = 6
) (
  // clock and reset
  input  wire                    CLK_SYS,
  input  wire                    NRST,
  // special-function bus
  input  wire [7:0]              SFR_ADDR,
  input  wire [7:0]              SFR_PAGE,
  input  wire                    SFR_WR,
  input  wire                    SFR_RD,
  input  wire [7:0]              SFR_WDATA,
  output wire [7:0]              SFR_RDATA,
  output wire                    SFR_RD_HIT,
  // global crossbar enable from the third routing register
  input  wire                    CROSSBAR_GLOBAL_ENABLE,
  // spi port
  input  wire                    SPI_FOUR_WIRE,
  input  wire                    SPI_SCK_OUT,
  input  wire                    SPI_SCK_OE,
  input  wire                    SPI_MISO_OUT,
  input  wire                    SPI_MISO_OE,
  input  wire                    SPI_MOSI_OUT,
  input  wire                    SPI_MOSI_OE,
  input  wire                    SPI_NSS_OUT,
  input  wire                    SPI_NSS_OE,
  output wire                    SPI_SCK_IN,
  output wire                    SPI_MISO_IN,
  output wire                    SPI_MOSI_IN,
  output wire                    SPI_NSS_IN,
  // two-wire bus, open drain, a zero pulls low
  input  wire                    TWOWIRE_SDA_OUT,
  input  wire                    TWOWIRE_SCL_OUT,
  output wire                    TWOWIRE_SDA_IN,
  output wire                    TWOWIRE_SCL_IN,
  // comparators
  input  wire                    COMPARATOR_ZERO_OUT,
  input  wire                    COMPARATOR_ZERO_ASYNC_OUT,
  input  wire                    COMPARATOR_ONE_OUT,
  input  wire                    COMPARATOR_ONE_ASYNC_OUT,
  // capture modules
  input  wire [CEX_COUNT-1:0]    CAPTURE_MODULE_IO_OUT,
  input  wire [CEX_COUNT-1:0]    CAPTURE_MODULE_IO_OE,
  output wire [CEX_COUNT-1:0]    CAPTURE_MODULE_IO_IN,
  // counter and timer inputs
  output wire                    COUNTER_EXT_INPUT,
  output wire                    TIMER_ZERO_INPUT,
  output wire                    TIMER_ONE_INPUT,
  // uart on fixed pins
  input  wire                    UART_TX_OUT,
  input  wire                    UART_RX_PIN,
  output wire                    UART_TX_PIN,
  output wire                    UART_TX_PIN_OE,
  output wire                    UART_PINS_CLAIMED,
  output wire                    UART_RX_IN,
  // toward the priority decoder
  input  wire [`PCPE_SLOTS-1:0]  SLOT_PIN_IN,
  output wire [`PCPE_SLOTS-1:0]  SLOT_REQ,
  output wire [`PCPE_SLOTS-1:0]  SLOT_VAL,
  output wire [`PCPE_SLOTS-1:0]  SLOT_OE,
  output wire                    SYSTEM_CLOCK_OUT_EN
);

  wire [7:0]             select_a;
  wire [7:0]             select_b;
  wire [2:0]             cex_code;
  wire [CEX_COUNT-1:0]   cex_route;
  reg  [`PCPE_SLOTS-1:0] req_nxt;
  reg  [`PCPE_SLOTS-1:0] val_nxt;
  reg  [`PCPE_SLOTS-1:0] oe_nxt;
  wire [`PCPE_SLOTS-1:0] pin_ok;
  integer                i;
  integer                j;
  // flip-flops behind the outputs
  reg  [`PCPE_SLOTS-1:0] slot_req_r;
  reg  [`PCPE_SLOTS-1:0] slot_val_r;
  reg  [`PCPE_SLOTS-1:0] slot_oe_r;
  reg                    system_clock_out_en_r;
  reg                    uart_claimed_r;
  reg                    uart_tx_r;
  reg                    uart_tx_oe_r;
  reg                    uart_rx_r;
  reg                    spi_sck_in_r;
  reg                    spi_miso_in_r;
  reg                    spi_mosi_in_r;
  reg                    spi_nss_in_r;
  reg                    sda_in_r;
  reg                    scl_in_r;
  reg  [CEX_COUNT-1:0]   cex_in_r;
  reg                    eci_in_r;
  reg                    t0_in_r;
  reg                    t1_in_r;

  // thermometer of routed capture modules, reserved code routes none
  function [CEX_COUNT-1:0] cex_mask;
    input [2:0] code;
    integer k;
    begin
      cex_mask = {CEX_COUNT{1'b0}};
      for (k = 0; k < CEX_COUNT; k = k + 1) begin
        if ((code != `PCPE_CEX_RESERVED) && (k < code)) begin
          cex_mask[k] = 1'b1;
        end
      end
    end
  endfunction

  // pin level as seen by a peripheral, idle level when not routed
  function gate_in;
    input routed;
    input level;
    input idle;
    begin
      gate_in = routed ? level : idle;
    end
  endfunction

  pcpe_route_regs u_regs (
    .clk       (CLK_SYS),
    .nrst      (NRST),
    .sfr_addr  (SFR_ADDR),
    .sfr_page  (SFR_PAGE),
    .sfr_wr    (SFR_WR),
    .sfr_rd    (SFR_RD),
    .sfr_wdata (SFR_WDATA),
    .sfr_rdata (SFR_RDATA),
    .sfr_rd_hit(SFR_RD_HIT),
    .select_a  (select_a),
    .select_b  (select_b)
  );

  assign cex_code  = select_b[`PCPE_B_CEX_HI:`PCPE_B_CEX_LO];
  assign cex_route = cex_mask(cex_code);

  // request, drive value and drive enable per slot
  always @* begin
    req_nxt = {`PCPE_SLOTS{1'b0}};
    val_nxt = {`PCPE_SLOTS{1'b0}};
    oe_nxt  = {`PCPE_SLOTS{1'b0}};
    if (CROSSBAR_GLOBAL_ENABLE) begin
      if (select_a[`PCPE_A_SPI]) begin
        req_nxt[`PCPE_SL_SCK]  = 1'b1;
        req_nxt[`PCPE_SL_MISO] = 1'b1;
        req_nxt[`PCPE_SL_MOSI] = 1'b1;
        req_nxt[`PCPE_SL_NSS]  = SPI_FOUR_WIRE;
        val_nxt[`PCPE_SL_SCK]  = SPI_SCK_OUT;
        val_nxt[`PCPE_SL_MISO] = SPI_MISO_OUT;
        val_nxt[`PCPE_SL_MOSI] = SPI_MOSI_OUT;
        val_nxt[`PCPE_SL_NSS]  = SPI_NSS_OUT;
        oe_nxt[`PCPE_SL_SCK]   = SPI_SCK_OE;
        oe_nxt[`PCPE_SL_MISO]  = SPI_MISO_OE;
        oe_nxt[`PCPE_SL_MOSI]  = SPI_MOSI_OE;
        oe_nxt[`PCPE_SL_NSS]   = SPI_NSS_OE & SPI_FOUR_WIRE;
      end
      if (select_a[`PCPE_A_TWOWIRE]) begin
        req_nxt[`PCPE_SL_SDA] = 1'b1;
        req_nxt[`PCPE_SL_SCL] = 1'b1;
        oe_nxt[`PCPE_SL_SDA]  = ~TWOWIRE_SDA_OUT;
        oe_nxt[`PCPE_SL_SCL]  = ~TWOWIRE_SCL_OUT;
      end
      if (select_a[`PCPE_A_CMP0_SYNC]) begin
        req_nxt[`PCPE_SL_CP0] = 1'b1;
        val_nxt[`PCPE_SL_CP0] = COMPARATOR_ZERO_OUT;
        oe_nxt[`PCPE_SL_CP0]  = 1'b1;
      end
      if (select_a[`PCPE_A_CMP0_ASYNC]) begin
        req_nxt[`PCPE_SL_CP0A] = 1'b1;
        val_nxt[`PCPE_SL_CP0A] = COMPARATOR_ZERO_ASYNC_OUT;
        oe_nxt[`PCPE_SL_CP0A]  = 1'b1;
      end
      if (select_a[`PCPE_A_CMP1_SYNC]) begin
        req_nxt[`PCPE_SL_CP1] = 1'b1;
        val_nxt[`PCPE_SL_CP1] = COMPARATOR_ONE_OUT;
        oe_nxt[`PCPE_SL_CP1]  = 1'b1;
      end
      if (select_a[`PCPE_A_CMP1_ASYNC]) begin
        req_nxt[`PCPE_SL_CP1A] = 1'b1;
        val_nxt[`PCPE_SL_CP1A] = COMPARATOR_ONE_ASYNC_OUT;
        oe_nxt[`PCPE_SL_CP1A]  = 1'b1;
      end
      if (select_b[`PCPE_B_SYSTEM_CLOCK_OUT]) begin
        req_nxt[`PCPE_SL_SYSTEM_CLOCK_OUT] = 1'b1;
        val_nxt[`PCPE_SL_SYSTEM_CLOCK_OUT] = 1'b1;
        oe_nxt[`PCPE_SL_SYSTEM_CLOCK_OUT]  = 1'b1;
      end
      for (i = 0; i < CEX_COUNT; i = i + 1) begin
        if (cex_route[i]) begin
          req_nxt[`PCPE_SL_CAPTURE_MODULE_IO_0 + i] = 1'b1;
          val_nxt[`PCPE_SL_CAPTURE_MODULE_IO_0 + i] = CAPTURE_MODULE_IO_OUT[i];
          oe_nxt[`PCPE_SL_CAPTURE_MODULE_IO_0 + i]  = CAPTURE_MODULE_IO_OE[i];
        end
      end
      req_nxt[`PCPE_SL_ECI] = select_b[`PCPE_B_ECI];
      req_nxt[`PCPE_SL_T0]  = select_b[`PCPE_B_TIMER0];
      req_nxt[`PCPE_SL_T1]  = select_b[`PCPE_B_TIMER1];
    end
  end

  // a slot returns pin level only while it was requested
  assign pin_ok = slot_req_r;

  // registered requests and drives toward the decoder
  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      slot_req_r  <= {`PCPE_SLOTS{1'b0}};
      slot_val_r  <= {`PCPE_SLOTS{1'b0}};
      slot_oe_r   <= {`PCPE_SLOTS{1'b0}};
      system_clock_out_en_r <= 1'b0;
    end else begin
      slot_req_r  <= req_nxt;
      slot_val_r  <= val_nxt;
      slot_oe_r   <= oe_nxt;
      system_clock_out_en_r <= req_nxt[`PCPE_SL_SYSTEM_CLOCK_OUT];
    end
  end

  // uart on its fixed pins, outside crossbar priority
  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      uart_claimed_r <= 1'b0;
      uart_tx_r      <= 1'b1;
      uart_tx_oe_r   <= 1'b0;
      uart_rx_r      <= 1'b1;
    end else begin
      uart_claimed_r <= CROSSBAR_GLOBAL_ENABLE & select_a[`PCPE_A_UART];
      uart_tx_r      <= UART_TX_OUT;
      uart_tx_oe_r   <= CROSSBAR_GLOBAL_ENABLE & select_a[`PCPE_A_UART];
      uart_rx_r      <= gate_in(uart_claimed_r, UART_RX_PIN, 1'b1);
    end
  end

  // pin levels handed back to the peripherals
  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      spi_sck_in_r  <= 1'b0;
      spi_miso_in_r <= 1'b0;
      spi_mosi_in_r <= 1'b0;
      spi_nss_in_r  <= 1'b1;
      sda_in_r      <= 1'b1;
      scl_in_r      <= 1'b1;
      cex_in_r      <= {CEX_COUNT{1'b0}};
      eci_in_r      <= 1'b0;
      t0_in_r       <= 1'b0;
      t1_in_r       <= 1'b0;
    end else begin
      spi_sck_in_r  <= gate_in(pin_ok[`PCPE_SL_SCK], SLOT_PIN_IN[`PCPE_SL_SCK], 1'b0);
      spi_miso_in_r <= gate_in(pin_ok[`PCPE_SL_MISO], SLOT_PIN_IN[`PCPE_SL_MISO], 1'b0);
      spi_mosi_in_r <= gate_in(pin_ok[`PCPE_SL_MOSI], SLOT_PIN_IN[`PCPE_SL_MOSI], 1'b0);
      spi_nss_in_r  <= gate_in(pin_ok[`PCPE_SL_NSS], SLOT_PIN_IN[`PCPE_SL_NSS], 1'b1);
      sda_in_r      <= gate_in(pin_ok[`PCPE_SL_SDA], SLOT_PIN_IN[`PCPE_SL_SDA], 1'b1);
      scl_in_r      <= gate_in(pin_ok[`PCPE_SL_SCL], SLOT_PIN_IN[`PCPE_SL_SCL], 1'b1);
      for (j = 0; j < CEX_COUNT; j = j + 1) begin
        cex_in_r[j] <= gate_in(pin_ok[`PCPE_SL_CAPTURE_MODULE_IO_0 + j],
                               SLOT_PIN_IN[`PCPE_SL_CAPTURE_MODULE_IO_0 + j], 1'b0);
      end
      eci_in_r      <= gate_in(pin_ok[`PCPE_SL_ECI], SLOT_PIN_IN[`PCPE_SL_ECI], 1'b0);
      t0_in_r       <= gate_in(pin_ok[`PCPE_SL_T0], SLOT_PIN_IN[`PCPE_SL_T0], 1'b0);
      t1_in_r       <= gate_in(pin_ok[`PCPE_SL_T1], SLOT_PIN_IN[`PCPE_SL_T1], 1'b0);
    end
  end

  // outputs straight from their flip-flops
  assign SLOT_REQ             = slot_req_r;
  assign SLOT_VAL             = slot_val_r;
  assign SLOT_OE              = slot_oe_r;
  assign SYSTEM_CLOCK_OUT_EN  = system_clock_out_en_r;
  assign UART_PINS_CLAIMED    = uart_claimed_r;
  assign UART_TX_PIN          = uart_tx_r;
  assign UART_TX_PIN_OE       = uart_tx_oe_r;
  assign UART_RX_IN           = uart_rx_r;
  assign SPI_SCK_IN           = spi_sck_in_r;
  assign SPI_MISO_IN          = spi_miso_in_r;
  assign SPI_MOSI_IN          = spi_mosi_in_r;
  assign SPI_NSS_IN           = spi_nss_in_r;
  assign TWOWIRE_SDA_IN       = sda_in_r;
  assign TWOWIRE_SCL_IN       = scl_in_r;
  assign CAPTURE_MODULE_IO_IN = cex_in_r;
  assign COUNTER_EXT_INPUT    = eci_in_r;
  assign TIMER_ZERO_INPUT     = t0_in_r;
  assign TIMER_ONE_INPUT      = t1_in_r;

endmodule

// ===== pcpe_crossbar_enables_sva.sv
// checker for the routing block, watching top-level ports only
// assumes one clock CLK_SYS and synchronous active-low NRST
`timescale 1ns/1ps
module pcpe_enables_sva #(
  parameter CEX_COUNT = 6
) (
  // clock and reset
  input wire        CLK_SYS,
  input wire        NRST,
  // register bus
  input wire        SFR_RD,
  input wire        SFR_RD_HIT,
  input wire [7:0]  SFR_ADDR,
  input wire [7:0]  SFR_PAGE,
  input wire [7:0]  SFR_RDATA,
  // peripheral side
  input wire        CROSSBAR_GLOBAL_ENABLE,
  input wire        SPI_FOUR_WIRE,
  input wire        TWOWIRE_SDA_OUT,
  input wire        TIMER_ZERO_INPUT,
  input wire        UART_TX_PIN_OE,
  input wire        UART_PINS_CLAIMED,
  input wire        SYSTEM_CLOCK_OUT_EN,
  // decoder side
  input wire [19:0] SLOT_REQ,
  input wire [19:0] SLOT_VAL,
  input wire [19:0] SLOT_OE,
  input wire [19:0] SLOT_PIN_IN
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  a_off_no_req: assert property (!CROSSBAR_GLOBAL_ENABLE |=>
    SLOT_REQ == 20'h0 && !UART_PINS_CLAIMED && !UART_TX_PIN_OE) else $error("routed while off");
  a_twowire_pair: assert property (SLOT_REQ[4] == SLOT_REQ[5]) else $error("sda scl split");
  a_sda_drain: assert property (SLOT_REQ[4] |->
    !SLOT_VAL[4] && SLOT_OE[4] == !$past(TWOWIRE_SDA_OUT)) else $error("sda not open drain");
  a_spi_group: assert property (SLOT_REQ[2:0] == {3{SLOT_REQ[0]}}) else $error("spi split");
  a_spi_nss: assert property (SLOT_REQ[3] |-> SLOT_REQ[0] && $past(SPI_FOUR_WIRE))
    else $error("nss without four wire");
  a_cex_thermo: assert property (((SLOT_REQ[16:11] + 6'h1) & SLOT_REQ[16:11]) == 6'h0)
    else $error("capture slots not from module 0");
  a_rd_hit: assert property (SFR_RD && SFR_PAGE == 8'h0f &&
    (SFR_ADDR == 8'he1 || SFR_ADDR == 8'he2) |=> SFR_RD_HIT) else $error("read missed");
  a_rd_miss: assert property (SFR_RD && SFR_PAGE != 8'h0f |=>
    !SFR_RD_HIT && SFR_RDATA == 8'h0) else $error("read hit wrong page");
  a_rsvd_zero: assert property (SFR_RD_HIT |->
    (SFR_RDATA & ($past(SFR_ADDR[0]) ? 8'h02 : 8'h01)) == 8'h0) else $error("reserved bit set");
  a_system_clock_out_val: assert property (SLOT_REQ[10] |-> SLOT_VAL[10] && SYSTEM_CLOCK_OUT_EN)
    else $error("clock slot wrong");
  a_unrouted_quiet: assert property (SLOT_OE[19:17] == 3'h0 &&
    (SLOT_OE & ~SLOT_REQ) == 20'h0) else $error("oe on input or unrouted slot");
  a_tmr0_return: assert property (TIMER_ZERO_INPUT ==
    ($past(SLOT_REQ[18]) && $past(SLOT_PIN_IN[18]))) else $error("timer 0 return wrong");
  a_uart_oe: assert property (UART_TX_PIN_OE == UART_PINS_CLAIMED) else $error("tx oe");
endmodule

bind pcpe_crossbar_enables pcpe_enables_sva #(.CEX_COUNT(CEX_COUNT)) u_sva (
  .CLK_SYS, .NRST, .CROSSBAR_GLOBAL_ENABLE, .SPI_FOUR_WIRE, .TWOWIRE_SDA_OUT, .SFR_RD,
  .SFR_RD_HIT, .TIMER_ZERO_INPUT, .UART_TX_PIN_OE, .UART_PINS_CLAIMED, .SYSTEM_CLOCK_OUT_EN,
  .SFR_ADDR, .SFR_PAGE, .SFR_RDATA, .SLOT_REQ, .SLOT_VAL, .SLOT_OE, .SLOT_PIN_IN);

// ===== pcpe_decoder_model.sv
// pin-side model of the priority decoder, returning each slot's pin level
// assumes slot vectors from the routing block and outside levels from the bench
`timescale 1ns/1ps
module pcpe_decoder_model (
  // clock
  input  wire        CLK_SYS,
  // slot vectors
  input  wire [19:0] SLOT_REQ,
  input  wire [19:0] SLOT_VAL,
  input  wire [19:0] SLOT_OE,
  // outside drivers and pull-ups on undriven slots
  input  wire [19:0] ext_lvl,
  // pin levels back
  output wire [19:0] SLOT_PIN_IN
);
  reg [19:0] idle_r = 20'h0;
  // unplaced slots show a level that changes every cycle
  always @(posedge CLK_SYS) idle_r <= ~idle_r;
  // every requested slot owns a pin in vector order
  assign SLOT_PIN_IN = (SLOT_REQ & ((SLOT_OE & SLOT_VAL) | (~SLOT_OE & ext_lvl)))
                     | (~SLOT_REQ & idle_r);
endmodule

// ===== pcpe_crossbar_enables_tb.sv
// self-checking bench for the routing block and its register pair
// assumes the decoder model on the slot side and the bound checker
`timescale 1ns/1ps
module pcpe_crossbar_enables_tb;
  reg         CLK_SYS = 1'b0, NRST = 1'b0, SFR_WR = 1'b0, SFR_RD = 1'b0;
  reg  [7:0]  SFR_ADDR = 8'h0, SFR_PAGE = 8'h0, SFR_WDATA = 8'h0, ra, rb;
  reg         CROSSBAR_GLOBAL_ENABLE = 1'b0, SPI_FOUR_WIRE = 1'b0;
  reg         SPI_SCK_OUT = 1'b0, SPI_SCK_OE = 1'b0, SPI_MISO_OUT = 1'b0, SPI_MISO_OE = 1'b0;
  reg         SPI_MOSI_OUT = 1'b0, SPI_MOSI_OE = 1'b0, SPI_NSS_OUT = 1'b0, SPI_NSS_OE = 1'b0;
  reg         TWOWIRE_SDA_OUT = 1'b1, TWOWIRE_SCL_OUT = 1'b1, UART_TX_OUT = 1'b1, UART_RX_PIN = 1'b1;
  reg         COMPARATOR_ZERO_OUT = 1'b0, COMPARATOR_ZERO_ASYNC_OUT = 1'b0;
  reg         COMPARATOR_ONE_OUT = 1'b0, COMPARATOR_ONE_ASYNC_OUT = 1'b0;
  reg  [5:0]  CAPTURE_MODULE_IO_OUT = 6'h0, CAPTURE_MODULE_IO_OE = 6'h0;
  reg  [19:0] ext_lvl = 20'hfffff;
  wire [7:0]  SFR_RDATA;
  wire        SFR_RD_HIT, SPI_SCK_IN, SPI_MISO_IN, SPI_MOSI_IN, SPI_NSS_IN, TWOWIRE_SDA_IN;
  wire        TWOWIRE_SCL_IN, COUNTER_EXT_INPUT, TIMER_ZERO_INPUT, TIMER_ONE_INPUT, UART_TX_PIN;
  wire        UART_TX_PIN_OE, UART_PINS_CLAIMED, UART_RX_IN, SYSTEM_CLOCK_OUT_EN;
  wire [5:0]  CAPTURE_MODULE_IO_IN;
  wire [19:0] SLOT_PIN_IN, SLOT_REQ, SLOT_VAL, SLOT_OE;
  integer     error_cnt = 0, samples_checked = 0, cyc = 0, i;

  pcpe_crossbar_enables #(.CEX_COUNT(6)) DUT (
    .CLK_SYS, .NRST, .SFR_ADDR, .SFR_PAGE, .SFR_WR, .SFR_RD, .SFR_WDATA, .SFR_RDATA,
    .SFR_RD_HIT, .CROSSBAR_GLOBAL_ENABLE, .SPI_FOUR_WIRE, .SPI_SCK_OUT, .SPI_SCK_OE,
    .SPI_MISO_OUT, .SPI_MISO_OE, .SPI_MOSI_OUT, .SPI_MOSI_OE, .SPI_NSS_OUT, .SPI_NSS_OE,
    .SPI_SCK_IN, .SPI_MISO_IN, .SPI_MOSI_IN, .SPI_NSS_IN, .TWOWIRE_SDA_OUT, .TWOWIRE_SCL_OUT,
    .TWOWIRE_SDA_IN, .TWOWIRE_SCL_IN, .COMPARATOR_ZERO_OUT, .COMPARATOR_ZERO_ASYNC_OUT,
    .COMPARATOR_ONE_OUT, .COMPARATOR_ONE_ASYNC_OUT, .CAPTURE_MODULE_IO_OUT,
    .CAPTURE_MODULE_IO_OE, .CAPTURE_MODULE_IO_IN, .COUNTER_EXT_INPUT, .TIMER_ZERO_INPUT,
    .TIMER_ONE_INPUT, .UART_TX_OUT, .UART_RX_PIN, .UART_TX_PIN, .UART_TX_PIN_OE,
    .UART_PINS_CLAIMED, .UART_RX_IN, .SLOT_PIN_IN, .SLOT_REQ, .SLOT_VAL, .SLOT_OE,
    .SYSTEM_CLOCK_OUT_EN);
  pcpe_decoder_model u_dec (.CLK_SYS, .SLOT_REQ, .SLOT_VAL, .SLOT_OE, .ext_lvl, .SLOT_PIN_IN);

  always #20 CLK_SYS = ~CLK_SYS;

  task chk(input [8*8:1] nm, input [19:0] seen, input [19:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge CLK_SYS);
      #1;
    end
  endtask

  task wr(input [7:0] pg, input [7:0] ad, input [7:0] dt);
    begin
      @(posedge CLK_SYS);
      {SFR_WR, SFR_PAGE, SFR_ADDR, SFR_WDATA} <= {1'b1, pg, ad, dt};
      @(posedge CLK_SYS);
      SFR_WR <= 1'b0;
    end
  endtask

  task rd(input [7:0] pg, input [7:0] ad, input [7:0] exp, input hit);
    begin
      @(posedge CLK_SYS);
      {SFR_RD, SFR_PAGE, SFR_ADDR} <= {1'b1, pg, ad};
      @(posedge CLK_SYS);
      SFR_RD <= 1'b0;
      #1;
      chk("rdata", SFR_RDATA, exp);
      chk("rd_hit", SFR_RD_HIT, hit);
    end
  endtask

  // requests expected from both registers, global enable and spi mode
  function [19:0] ereq(input [7:0] a, input [7:0] b, input en, input fw);
    integer k;
    begin
      ereq = {b[7:5], 6'h0, b[1], a[7:4], {2{a[3]}}, a[2] & fw, {3{a[2]}}};
      for (k = 0; k < 6; k = k + 1)
        ereq[11 + k] = (b[4:2] != 3'h7) && (k < b[4:2]);
      if (!en)
        ereq = 20'h0;
    end
  endfunction

  task close_out;
    begin
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  always @(posedge CLK_SYS) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end

  initial begin
    repeat (12) @(posedge CLK_SYS);
    NRST <= 1'b1;
    rd(8'h0f, 8'he1, 8'h00, 1'b1);
    rd(8'h0f, 8'he2, 8'h00, 1'b1);
    chk("tx_pin", UART_TX_PIN, 1);
    // map, reserved bits, wrong page and unmapped address
    wr(8'h0f, 8'he1, 8'hff);
    wr(8'h0f, 8'he2, 8'hfb);
    wr(8'h00, 8'he1, 8'h00);
    wr(8'h0f, 8'he3, 8'h00);
    rd(8'h0f, 8'he1, 8'hfd, 1'b1);
    rd(8'h0f, 8'he2, 8'hfa, 1'b1);
    rd(8'h00, 8'he1, 8'h00, 1'b0);
    rd(8'h0f, 8'he3, 8'h00, 1'b0);
    chk("req_off", SLOT_REQ, 0);
    // everything routed with all peripheral drivers high
    @(posedge CLK_SYS);
    {CROSSBAR_GLOBAL_ENABLE, SPI_FOUR_WIRE, CAPTURE_MODULE_IO_OUT, CAPTURE_MODULE_IO_OE} <= ~14'h0;
    {SPI_SCK_OUT, SPI_SCK_OE, SPI_MISO_OUT, SPI_MISO_OE, SPI_MOSI_OUT, SPI_MOSI_OE} <= 6'h3f;
    {SPI_NSS_OUT, SPI_NSS_OE, COMPARATOR_ZERO_OUT, COMPARATOR_ZERO_ASYNC_OUT} <= 4'hf;
    {COMPARATOR_ONE_OUT, COMPARATOR_ONE_ASYNC_OUT} <= 2'h3;
    tick(3);
    chk("req_all", SLOT_REQ, ereq(8'hfd, 8'hfa, 1'b1, 1'b1));
    chk("val_all", SLOT_VAL, 20'h1ffcf);
    chk("oe_all", SLOT_OE, 20'h1ffcf);
    chk("mosi_in", SPI_MOSI_IN, 1);
    chk("sck_in", SPI_SCK_IN, 1);
    chk("cex_in", CAPTURE_MODULE_IO_IN, 6'h3f);
    chk("clk_en", SYSTEM_CLOCK_OUT_EN, 1);
    chk("sda_in", TWOWIRE_SDA_IN, 1);
    @(posedge CLK_SYS);
    TWOWIRE_SDA_OUT <= 1'b0;
    tick(3);
    chk("sda_low", TWOWIRE_SDA_IN, 0);
    // walk each enable bit with capture code bit 0 held set, spi mode alternating
    for (i = 0; i < 16; i = i + 1) begin
      ra = (i < 8) ? (8'h01 << i) : 8'h00;
      rb = (i < 8) ? 8'h00 : (8'h01 << (i - 8));
      wr(8'h0f, 8'he1, ra & 8'hfd);
      wr(8'h0f, 8'he2, (rb & 8'hfe) | 8'h04);
      SPI_FOUR_WIRE <= i[0];
      tick(2);
      chk("req_bit", SLOT_REQ, ereq(ra, rb | 8'h04, 1'b1, i[0]));
    end
    // every legal capture module count
    for (i = 0; i < 7; i = i + 1) begin
      wr(8'h0f, 8'he2, i << 2);
      tick(2);
      chk("cex_cnt", SLOT_REQ, ereq(8'h00, i << 2, 1'b1, 1'b0));
    end
    // pin returns of routed and unrouted inputs
    wr(8'h0f, 8'he2, 8'h40);
    tick(3);
    chk("t0_in", TIMER_ZERO_INPUT, 1);
    chk("t1_in", TIMER_ONE_INPUT, 0);
    chk("eci_in", COUNTER_EXT_INPUT, 0);
    @(posedge CLK_SYS);
    ext_lvl <= 20'h0;
    tick(1);
    chk("t0_low", TIMER_ZERO_INPUT, 0);
    // uart on fixed pins, then crossbar switched off
    wr(8'h0f, 8'he1, 8'h01);
    {UART_TX_OUT, UART_RX_PIN} <= 2'h0;
    tick(3);
    chk("claimed", UART_PINS_CLAIMED, 1);
    chk("tx_pin", UART_TX_PIN, 0);
    chk("rx_in", UART_RX_IN, 0);
    chk("tx_oe", UART_TX_PIN_OE, 1);
    @(posedge CLK_SYS);
    CROSSBAR_GLOBAL_ENABLE <= 1'b0;
    tick(3);
    chk("clm_off", UART_PINS_CLAIMED, 0);
    chk("rx_off", UART_RX_IN, 1);
    chk("txoe_off", UART_TX_PIN_OE, 0);
    chk("req_off", SLOT_REQ, 0);
    // reset in mid-run clears both registers
    @(posedge CLK_SYS);
    NRST <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    NRST <= 1'b1;
    rd(8'h0f, 8'he1, 8'h00, 1'b1);
    rd(8'h0f, 8'he2, 8'h00, 1'b1);
    close_out;
  end
endmodule
